// >>> logic/ldc_pkg.sv
// constants, types and register map of the link-drop / crossover register bank
// assumes one 25 MHz core clock and a plain one-cycle register port
// Contract
// RULE_01: fast link-drop criteria are evaluated over a window set by the 5-bit count in bits 13-9, reset 10 (about 10 us).
// RULE_02: in forced 100M fast crossover mode the crossover flips at the interval of the 5-bit timer in bits 8-4 (about 4 ms).
// RULE_03: in robust crossover mode the crossover flips at the interval of the 4-bit timer in bits 3-0, reset 15 (about 0.5 s).
// RULE_04: with the drop-link enable in bit 15 set, transmission stops and the link drops once no signal is received.
// RULE_05: with the wait-skip bit 14 set, the maximum wait before dropping is skipped so the link drops sooner.
// RULE_06: link-drop causes latch high in the read-only field at bits 12-8 and clear when software reads it.
// RULE_07: the 5-bit criteria field at bits 4-0 enables energy loss, mse, mlt3 errors, receive errors and sync loss, one bit each.
// RULE_08: in energy-loss mode the energy accumulator window is sized by the 3-bit field at bits 10-8, reset 2.
// RULE_09: energy-present is asserted when the accumulator exceeds the 3-bit level in bits 6-4.
// RULE_10: energy-absent is asserted when the accumulator falls below the 3-bit level in bits 2-0, reset 1.
// RULE_11: bits 6-5 select the serial negotiation timer: 00 1.6 ms, 01 2 us, 10 800 us, 11 11 ms, reset 01.
// RULE_12: bit 0 of the general configuration register enables port mirroring, reset disabled.
// RULE_13: read-only reserved bits read zero and writes to them have no effect.
// RULE_14: each latched cause bit sits at the position of the criterion bit that caused the drop.
`default_nettype none
package ldc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_XOVER_TIMING = 8'h2C;
  localparam logic [7:0] OFS_DROP_CTRL = 8'h2D;
  localparam logic [7:0] OFS_ENERGY_LEVELS = 8'h2E;
  localparam logic [7:0] OFS_GENERAL_CONFIG_THREE = 8'h31;
  localparam logic [7:0] OFS_RGMII_CTRL = 8'h32;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h39;
  localparam logic [15:0] RST_XOVER_TIMING = 16'h141F;
  localparam logic [15:0] RST_DROP_CTRL = 16'h0000;
  localparam logic [15:0] RST_ENERGY_LEVELS = 16'h0221;
  localparam logic [15:0] RST_GENERAL_CONFIG_THREE = 16'h10B0;
  localparam logic [15:0] RST_RGMII_CTRL = 16'h00D0;
  localparam logic [15:0] WMASK_XOVER_TIMING = 16'h3FFF;
  localparam logic [15:0] WMASK_DROP_CTRL = 16'hC01F;
  localparam logic [15:0] WMASK_ENERGY_LEVELS = 16'h0777;
  localparam logic [15:0] WMASK_GENERAL_CONFIG_THREE = 16'h71FD;
  localparam logic [15:0] WMASK_RGMII_CTRL = 16'h0BFF;
  // field positions
  localparam int WIN_CNT_LSB = 9;
  localparam int QUICK_XOVER_LSB = 4;
  localparam int PATIENT_XOVER_LSB = 0;
  localparam int FORCE_DROP_BIT = 15;
  localparam int SKIP_WAIT_BIT = 14;
  localparam int SLICER_STUCK_BIT = 13;
  localparam int CAUSE_LSB = 8;
  localparam int CRIT_LSB = 0;
  localparam int ENERGY_WIN_LSB = 8;
  localparam int PRESENT_LVL_LSB = 4;
  localparam int ABSENT_LVL_LSB = 0;
  localparam int NEG_SEL_LSB = 5;
  localparam int MIRROR_BIT = 0;
  localparam int IRQ_W = 4;
  localparam int IRQ_CAUSE = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_ENERGY_LOST = 2;
  localparam int IRQ_NEG_DONE = 3;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int WIN_UNIT_NS = 1000;
  localparam int WIN_UNIT_CYC = (WIN_UNIT_NS * CLK_MHZ) / 1000;
  localparam int MAX_WAIT_US = 100;
  localparam int MAX_WAIT_CYC = MAX_WAIT_US * CLK_MHZ;
  localparam int QUICK_XOVER_UNIT_US = 4000;
  localparam int PATIENT_XOVER_UNIT_US = 33333;
  localparam int NEG_1P6MS_US = 1600;
  localparam int NEG_2US_NS = 2000;
  localparam int NEG_2US_CYC = (NEG_2US_NS * CLK_MHZ) / 1000;
  localparam int NEG_800US_US = 800;
  localparam int NEG_11MS_US = 11000;
  localparam logic [1:0] NEG_SEL_1P6MS = 2'h0;
  localparam logic [1:0] NEG_SEL_2US = 2'h1;
  localparam logic [1:0] NEG_SEL_800US = 2'h2;

  typedef struct packed {
    logic slicer_stuck;
    logic rx_signal;
    logic energy_seen;
    logic desc_sync_loss;
    logic rx_err;
    logic mlt3_err;
    logic mse_bad;
  } ldc_sense_s;

  typedef enum logic [1:0] {DROP_IDLE, DROP_WAIT, DROP_DOWN} ldc_drop_e;
endpackage : ldc_pkg
`default_nettype wire

// >>> logic/ldc_regs.sv
// link-drop detector, crossover timers, negotiation timer and their registers
// assumes synchronous inputs, one-cycle strobes, read data one cycle after the read strobe
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ldc_regs
  import ldc_pkg::*;
#(
  parameter int QUICK_XOVER_UNIT_CYC = QUICK_XOVER_UNIT_US * CLK_MHZ,
  parameter int PATIENT_XOVER_UNIT_CYC = PATIENT_XOVER_UNIT_US * CLK_MHZ,
  parameter int NEG_1P6MS_CYC = NEG_1P6MS_US * CLK_MHZ,
  parameter int NEG_800US_CYC = NEG_800US_US * CLK_MHZ,
  parameter int NEG_11MS_CYC = NEG_11MS_US * CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire ldc_sense_s sense,
  input wire logic link_up,
  input wire logic quick_xover_mode,
  input wire logic neg_start,
  output logic link_drop,
  output logic mdix_sel,
  output logic energy_present,
  output logic energy_absent,
  output logic neg_timer_done,
  output logic mirror_en,
  output logic irq
);
  localparam int LOCAL_NEG_2US_CYC = NEG_2US_CYC;

  logic [15:0] xover_reg, dropcfg_reg, energy_reg, cfg3_reg, rgmii_reg, rdata_reg;
  logic [4:0] cause_reg, cause_next, seen_reg, crit_now, hits;
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_stat_next, irq_ev;
  logic [31:0] win_cnt_reg, win_len, unit_cnt_reg, xover_cnt_reg, xover_len, neg_cnt_reg, neg_len;
  logic [11:0] wait_cnt_reg;
  logic [3:0] acc_reg, acc_sum;
  logic [2:0] unit_idx_reg;
  logic unit_seen_reg, present_reg, absent_reg, drop_reg, mdix_reg, neg_run_reg, neg_done_reg, mirror_reg, irq_reg;
  ldc_drop_e drop_state_reg, drop_state_next;

  // address decode
  wire wr_xover = reg_wr && (reg_addr == OFS_XOVER_TIMING);
  wire wr_drop = reg_wr && (reg_addr == OFS_DROP_CTRL);
  wire wr_energy = reg_wr && (reg_addr == OFS_ENERGY_LEVELS);
  wire wr_cfg3 = reg_wr && (reg_addr == OFS_GENERAL_CONFIG_THREE);
  wire wr_rgmii = reg_wr && (reg_addr == OFS_RGMII_CTRL);
  wire wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);
  wire rd_drop = reg_rd && (reg_addr == OFS_DROP_CTRL);
  wire rd_irq = reg_rd && (reg_addr == OFS_IRQ_STATUS);

  // fields
  wire [4:0] win_field = xover_reg[WIN_CNT_LSB +: 5];
  wire [4:0] quick_field = xover_reg[QUICK_XOVER_LSB +: 5];
  wire [3:0] patient_field = xover_reg[PATIENT_XOVER_LSB +: 4];
  wire force_drop = dropcfg_reg[FORCE_DROP_BIT];
  wire skip_wait = dropcfg_reg[SKIP_WAIT_BIT];
  wire [4:0] crit_en = dropcfg_reg[CRIT_LSB +: 5];
  wire [2:0] ewin_field = energy_reg[ENERGY_WIN_LSB +: 3];
  wire [2:0] present_lvl = energy_reg[PRESENT_LVL_LSB +: 3];
  wire [2:0] absent_lvl = energy_reg[ABSENT_LVL_LSB +: 3];
  wire [1:0] neg_sel = cfg3_reg[NEG_SEL_LSB +: 2];

  // registers, write masks keep reserved and read-only bits at zero [RULE_13]
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      xover_reg <= RST_XOVER_TIMING;
      dropcfg_reg <= RST_DROP_CTRL;
      energy_reg <= RST_ENERGY_LEVELS;
      cfg3_reg <= RST_GENERAL_CONFIG_THREE;
      rgmii_reg <= RST_RGMII_CTRL;
      irq_mask_reg <= '0;
    end else begin
      if (wr_xover) xover_reg <= reg_wdata & WMASK_XOVER_TIMING; // [RULE_13]
      if (wr_drop) dropcfg_reg <= reg_wdata & WMASK_DROP_CTRL; // [RULE_13]
      if (wr_energy) energy_reg <= reg_wdata & WMASK_ENERGY_LEVELS; // [RULE_13]
      if (wr_cfg3) cfg3_reg <= reg_wdata & WMASK_GENERAL_CONFIG_THREE; // [RULE_13]
      if (wr_rgmii) rgmii_reg <= reg_wdata & WMASK_RGMII_CTRL; // [RULE_13]
      if (wr_mask) irq_mask_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  // evaluation window in 1 us units, zero count treated as one unit
  assign win_len = 32'(((win_field == 5'h00) ? 5'h01 : win_field)) * WIN_UNIT_CYC; // [RULE_01]
  assign crit_now = {sense.desc_sync_loss, sense.rx_err, sense.mlt3_err, sense.mse_bad, absent_reg};
  wire win_end = (win_cnt_reg == 32'h0000_0000);
  // each cause lands on the position of its criterion bit [RULE_14]
  assign hits = win_end ? ((seen_reg | crit_now) & crit_en) : 5'h00; // [RULE_07]
  // set wins over clear-on-read
  assign cause_next = (rd_drop ? 5'h00 : cause_reg) | hits; // [RULE_06]

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      win_cnt_reg <= '0;
      seen_reg <= '0;
      cause_reg <= '0;
    end else begin
      win_cnt_reg <= win_end ? (win_len - 32'h0000_0001) : (win_cnt_reg - 32'h0000_0001); // [RULE_01]
      seen_reg <= win_end ? 5'h00 : (seen_reg | crit_now);
      cause_reg <= cause_next; // [RULE_06]
    end
  end

  // energy accumulator: counts units with energy over (field + 1) units
  wire unit_end = (unit_cnt_reg == 32'(WIN_UNIT_CYC - 1));
  wire unit_got = unit_seen_reg | sense.energy_seen;
  wire ewin_last = unit_end && (unit_idx_reg == ewin_field); // [RULE_08]
  assign acc_sum = acc_reg + {3'h0, unit_got};

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      unit_cnt_reg <= '0;
      unit_seen_reg <= 1'b0;
      unit_idx_reg <= '0;
      acc_reg <= '0;
      present_reg <= 1'b0;
      absent_reg <= 1'b0;
    end else begin
      unit_cnt_reg <= unit_end ? 32'h0000_0000 : (unit_cnt_reg + 32'h0000_0001);
      unit_seen_reg <= unit_end ? 1'b0 : unit_got;
      if (unit_end) begin
        unit_idx_reg <= ewin_last ? 3'h0 : (unit_idx_reg + 3'h1); // [RULE_08]
        acc_reg <= ewin_last ? 4'h0 : acc_sum;
      end
      if (ewin_last) begin
        present_reg <= acc_sum > {1'b0, present_lvl}; // [RULE_09]
        absent_reg <= acc_sum < {1'b0, absent_lvl}; // [RULE_10]
      end
    end
  end

  // drop sequencer
  wire drop_req = (|hits) || (force_drop && !sense.rx_signal); // [RULE_04]
  always_comb begin
    drop_state_next = drop_state_reg;
    unique case (drop_state_reg)
      DROP_IDLE: if (drop_req) drop_state_next = skip_wait ? DROP_DOWN : DROP_WAIT; // [RULE_05]
      DROP_WAIT: if (wait_cnt_reg == 12'(MAX_WAIT_CYC - 1)) drop_state_next = DROP_DOWN; // [RULE_05]
      DROP_DOWN: if (sense.rx_signal && !absent_reg && !(|hits)) drop_state_next = DROP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      drop_state_reg <= DROP_IDLE;
      wait_cnt_reg <= '0;
      drop_reg <= 1'b0;
    end else begin
      drop_state_reg <= drop_state_next;
      wait_cnt_reg <= (drop_state_reg == DROP_WAIT) ? (wait_cnt_reg + 12'h001) : 12'h000;
      drop_reg <= (drop_state_reg == DROP_DOWN); // [RULE_04]
    end
  end

  // crossover flip timer, held while the link is up
  assign xover_len = quick_xover_mode ?
    32'(((quick_field == 5'h00) ? 5'h01 : quick_field)) * QUICK_XOVER_UNIT_CYC : // [RULE_02]
    32'(((patient_field == 4'h0) ? 4'h1 : patient_field)) * PATIENT_XOVER_UNIT_CYC; // [RULE_03]
  wire xover_flip = !link_up && (xover_cnt_reg == 32'h0000_0000);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      xover_cnt_reg <= '0;
      mdix_reg <= 1'b0;
    end else begin
      if (link_up || xover_flip) xover_cnt_reg <= xover_len - 32'h0000_0001; // [RULE_02] [RULE_03]
      else xover_cnt_reg <= xover_cnt_reg - 32'h0000_0001;
      if (xover_flip) mdix_reg <= !mdix_reg;
    end
  end

  // serial negotiation timer
  assign neg_len = (neg_sel == NEG_SEL_1P6MS) ? 32'(NEG_1P6MS_CYC) :
                   (neg_sel == NEG_SEL_2US) ? 32'(LOCAL_NEG_2US_CYC) :
                   (neg_sel == NEG_SEL_800US) ? 32'(NEG_800US_CYC) : 32'(NEG_11MS_CYC); // [RULE_11]
  wire neg_expire = neg_run_reg && (neg_cnt_reg == 32'h0000_0000);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      neg_cnt_reg <= '0;
      neg_run_reg <= 1'b0;
      neg_done_reg <= 1'b0;
    end else begin
      if (neg_start) neg_cnt_reg <= neg_len - 32'h0000_0001; // [RULE_11]
      else if (neg_run_reg) neg_cnt_reg <= neg_cnt_reg - 32'h0000_0001;
      neg_run_reg <= neg_start || (neg_run_reg && !neg_expire);
      neg_done_reg <= neg_expire && !neg_start;
    end
  end

  // cycles since the last timer start, seen by the 2 us length checks
  logic [7:0] neg_age_reg;
  logic neg_2us_reg;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      neg_age_reg <= '0;
      neg_2us_reg <= 1'b0;
    end else begin
      if (neg_start) begin
        neg_age_reg <= 8'h01;
        neg_2us_reg <= (neg_sel == NEG_SEL_2US);
      end else if (neg_age_reg != 8'hFF) begin
        neg_age_reg <= neg_age_reg + 8'h01;
      end
    end
  end

  // interrupts: sticky, cleared by reading, set wins
  assign irq_ev[IRQ_CAUSE] = |hits;
  assign irq_ev[IRQ_DROP] = (drop_state_reg == DROP_DOWN) && !drop_reg;
  assign irq_ev[IRQ_ENERGY_LOST] = ewin_last && (acc_sum < {1'b0, absent_lvl}) && !absent_reg;
  assign irq_ev[IRQ_NEG_DONE] = neg_expire && !neg_start;
  assign irq_stat_next = (rd_irq ? '0 : irq_stat_reg) | irq_ev;

  // read mux, unmapped addresses read zero
  wire [15:0] drop_word = dropcfg_reg | (16'(sense.slicer_stuck) << SLICER_STUCK_BIT) | (16'(cause_reg) << CAUSE_LSB);
  wire [15:0] rd_word = (reg_addr == OFS_XOVER_TIMING) ? xover_reg :
                        (reg_addr == OFS_DROP_CTRL) ? drop_word : // [RULE_06]
                        (reg_addr == OFS_ENERGY_LEVELS) ? energy_reg :
                        (reg_addr == OFS_GENERAL_CONFIG_THREE) ? cfg3_reg :
                        (reg_addr == OFS_RGMII_CTRL) ? rgmii_reg :
                        (reg_addr == OFS_IRQ_STATUS) ? 16'(irq_stat_reg) :
                        (reg_addr == OFS_IRQ_MASK) ? 16'(irq_mask_reg) : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
      mirror_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
      rdata_reg <= reg_rd ? rd_word : 16'h0000;
      mirror_reg <= cfg3_reg[MIRROR_BIT]; // [RULE_12]
    end
  end

  assign reg_rdata = rdata_reg;
  assign link_drop = drop_reg;
  assign mdix_sel = mdix_reg;
  assign energy_present = present_reg;
  assign energy_absent = absent_reg;
  assign neg_timer_done = neg_done_reg;
  assign mirror_en = mirror_reg;
  assign irq = irq_reg;

  AST_CAUSE_CLEARED_BY_READ: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_06]
    rd_drop && !(|hits) |=> cause_reg == 5'h00)
    else $error("cause flags not cleared by read");

  AST_CAUSE_AT_CRIT_POS: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_14]
    (|hits) |=> ((cause_reg & $past(hits)) == $past(hits)) && ((cause_reg & ~$past(crit_en)) == 5'h00 || $past(cause_reg) != 5'h00))
    else $error("cause flag not at criterion position");

  AST_RESERVED_READ_ZERO: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_13]
    reg_rd && (reg_addr == OFS_ENERGY_LEVELS) |=> (reg_rdata & ~WMASK_ENERGY_LEVELS) == 16'h0000)
    else $error("reserved bits read nonzero");

  AST_SKIP_WAIT_DROP: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_05]
    (drop_state_reg == DROP_IDLE) && drop_req && skip_wait |=> ##1 link_drop)
    else $error("skip-wait drop not immediate");

  AST_WAIT_BEFORE_DROP: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_05]
    (drop_state_reg == DROP_IDLE) && drop_req && !skip_wait |=> (drop_state_reg == DROP_WAIT) ##1 !link_drop)
    else $error("drop did not wait");

  AST_FORCE_DROP_NO_SIGNAL: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_04]
    (drop_state_reg == DROP_IDLE) && force_drop && !sense.rx_signal && skip_wait |-> ##2 link_drop)
    else $error("no-signal drop missing");

  AST_MIRROR_FOLLOWS_WRITE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_12]
    wr_cfg3 ##1 !wr_cfg3 |=> mirror_en == $past(reg_wdata[MIRROR_BIT], 2))
    else $error("mirror enable does not follow write");

  AST_XOVER_FLIPS: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_02]
    nrst && xover_flip |=> mdix_sel != $past(mdix_sel) && xover_cnt_reg == $past(xover_len) - 32'h0000_0001)
    else $error("crossover did not flip with reload");

  AST_ENERGY_PRESENT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_09]
    ewin_last |=> energy_present == ($past(acc_sum) > {1'b0, $past(present_lvl)}))
    else $error("energy-present wrong after window");

  AST_NEG_2US: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_11]
    neg_2us_reg && (neg_age_reg == 8'(LOCAL_NEG_2US_CYC + 1)) |-> neg_timer_done)
    else $error("2 us negotiation timer wrong length");
  AST_NEG_2US_NOT_EARLY: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_11]
    neg_2us_reg && (neg_age_reg <= 8'(LOCAL_NEG_2US_CYC)) |-> !neg_timer_done)
    else $error("2 us negotiation timer ended early");
  AST_NEG_DONE_PULSE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_11]
    neg_timer_done |=> !neg_timer_done)
    else $error("negotiation done longer than one cycle");
  AST_ENERGY_ABSENT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_10]
    ewin_last |=> energy_absent == ($past(acc_sum) < {1'b0, $past(absent_lvl)}))
    else $error("energy-absent wrong after window");
  AST_WINDOW_RELOAD: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_01]
    nrst && win_end |=> win_cnt_reg == $past(win_len) - 32'h0000_0001)
    else $error("evaluation window reloaded wrongly");
  AST_XOVER_HOLD_UP: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_03]
    nrst && link_up |=> xover_cnt_reg == $past(xover_len) - 32'h0000_0001)
    else $error("crossover timer not held while link up");
  AST_IRQ_SET_WINS: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_ev != '0) |=> (irq_stat_reg & $past(irq_ev)) == $past(irq_ev))
    else $error("interrupt event lost against read clear");
  AST_RDATA_IDLE_ZERO: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_13]
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!nrst)
    irq == $past(|(irq_stat_reg & irq_mask_reg)))
    else $error("interrupt does not follow masked status");
endmodule : ldc_regs
`default_nettype wire

// >>> testbench/ldc_link_partner.sv
// link partner model: drives the receive-side sense levels and the link state
// assumes the bench steers presence and injected faults from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module ldc_link_partner
  import ldc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic present,
  input wire logic [3:0] fault,
  output var ldc_sense_s sense,
  output logic link_up
);
  logic [3:0] up_cnt_reg;
  // link comes up only after the far end has been heard for a while
  always_ff @(posedge core_clk) begin
    if (!nrst || !present) up_cnt_reg <= 4'h0;
    else if (up_cnt_reg != 4'hF) up_cnt_reg <= up_cnt_reg + 4'h1;
  end
  assign link_up = (up_cnt_reg == 4'hF);
  assign sense = '{1'b0, present, present, fault[3], fault[2], fault[1], fault[0]};
endmodule : ldc_link_partner
`default_nettype wire

// >>> testbench/test_link_drop_crossover_config.sv
// self-checking bench for the link-drop / crossover register bank
// assumes the partner model on the cable side and shortened timer parameters
`timescale 1ns/1ps
`default_nettype none
module test_link_drop_crossover_config;
  import ldc_pkg::*;
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic quick_xover_mode = 1'b0;
  logic neg_start = 1'b0;
  logic present = 1'b1;
  logic [3:0] fault = 4'h0;
  logic [15:0] reg_rdata;
  ldc_sense_s sense;
  logic link_up, link_drop, mdix_sel, energy_present, energy_absent, neg_timer_done, mirror_en, irq;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 12759;
  int n;
  logic [15:0] d;
  logic [7:0] ofs [6] = '{8'h2C, 8'h2D, 8'h2E, 8'h31, 8'h32, 8'h30};
  logic [15:0] msk [6] = '{16'h3FFF, 16'hC01F, 16'h0777, 16'h71FD, 16'h0BFF, 16'h0000};
  int negc [4] = '{40, 50, 20, 60};
  logic xm [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0] xv [4] = '{16'h0410, 16'h0432, 16'h0432, 16'h041F};
  int xp [4] = '{20, 60, 60, 450};
  logic [15:0] cm [5] = '{16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h000C};

  always #20 core_clk = ~core_clk;

  ldc_regs #(.QUICK_XOVER_UNIT_CYC(20), .PATIENT_XOVER_UNIT_CYC(30), .NEG_1P6MS_CYC(40), .NEG_800US_CYC(20),
    .NEG_11MS_CYC(60)) u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense(sense), .link_up(link_up),
    .quick_xover_mode(quick_xover_mode), .neg_start(neg_start), .link_drop(link_drop), .mdix_sel(mdix_sel),
    .energy_present(energy_present), .energy_absent(energy_absent), .neg_timer_done(neg_timer_done),
    .mirror_en(mirror_en), .irq(irq));
  ldc_link_partner u_partner (.core_clk(core_clk), .nrst(nrst), .present(present), .fault(fault),
    .sense(sense), .link_up(link_up));

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(name, v, exp);
  endtask : rchk
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  // counts cycles until link_drop reaches the wanted level, bounded
  task automatic wait_drop(input logic lvl, input int maxc, output int cnt);
    cnt = 0;
    #1;
    while (link_drop !== lvl && cnt < maxc) begin
      @(posedge core_clk);
      #1 cnt++;
    end
  endtask : wait_drop
  task automatic neg_time(output int cnt);
    @(posedge core_clk);
    neg_start <= 1'b1;
    @(posedge core_clk);
    neg_start <= 1'b0;
    cnt = 1;
    #1;
    while (neg_timer_done !== 1'b1 && cnt < 200) begin
      @(posedge core_clk);
      #1 cnt++;
    end
  endtask : neg_time
  // the last of three toggle gaps is a full interval under the new setting
  task automatic xover_period(output int cnt);
    logic s;
    repeat (3) begin
      s = mdix_sel;
      cnt = 0;
      while (mdix_sel === s && cnt < 2000) begin
        @(posedge core_clk);
        #1 cnt++;
      end
    end
  endtask : xover_period
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rchk("xover_timing", 8'h2C, 16'h141F);
    rchk("drop_ctrl", 8'h2D, 16'h0000);
    rchk("energy_levels", 8'h2E, 16'h0221);
    rchk("general_config_three", 8'h31, 16'h10B0);
    rchk("rgmii_ctrl", 8'h32, 16'h00D0);
    // random writes, reserved and read-only bits must not stick
    for (int i = 0; i < 24; i++) begin
      d = 16'($random(seed));
      if (i % 6 == 1) d[0] = 1'b0;
      wr(ofs[i % 6], d);
      rchk("rw_readback", ofs[i % 6], d & msk[i % 6]);
    end
    wr(8'h2C, 16'h041F);
    wr(8'h2D, 16'h0000);
    wr(8'h2E, 16'h0221);
    wr(8'h31, 16'h10B1);
    tick(1);
    chk("mirror_on", 16'(mirror_en), 16'h0001);
    for (int s = 0; s < 4; s++) begin
      wr(8'h31, 16'h1090 | (16'(s) << 5));
      neg_time(n);
      chk("neg_timer", 16'(n), 16'(negc[s] + 1));
    end
    chk("mirror_off", 16'(mirror_en), 16'h0000);
    rd(OFS_IRQ_STATUS, d);
    neg_time(n);
    tick(2);
    chk("irq_masked", 16'(irq), 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0008);
    tick(2);
    chk("irq_on", 16'(irq), 16'h0001);
    rchk("irq_status", OFS_IRQ_STATUS, 16'h0008);
    tick(2);
    chk("irq_cleared", 16'(irq), 16'h0000);
    // energy accumulator window and both thresholds
    tick(200);
    chk("energy_on", 16'({energy_present, energy_absent}), 16'h0002);
    wr(8'h2E, 16'h0231);
    tick(200);
    chk("present_at_level", 16'(energy_present), 16'h0000);
    wr(8'h2E, 16'h0331);
    tick(200);
    chk("wider_window", 16'(energy_present), 16'h0001);
    @(posedge core_clk);
    present <= 1'b0;
    tick(200);
    chk("energy_gone", 16'({energy_present, energy_absent}), 16'h0001);
    wr(8'h2E, 16'h0330);
    tick(200);
    chk("absent_level_zero", 16'(energy_absent), 16'h0000);
    // crossover intervals with no link
    for (int t = 0; t < 4; t++) begin
      @(posedge core_clk);
      quick_xover_mode <= xm[t];
      wr(8'h2C, xv[t]);
      xover_period(n);
      chk("xover_period", 16'(n), 16'(xp[t]));
    end
    @(posedge core_clk);
    present <= 1'b1;
    wr(8'h2E, 16'h0221);
    // fault criteria, alone and together, with a 50-cycle window
    for (int k = 0; k < 5; k++) begin
      rd(8'h2D, d);
      wr(8'h2D, 16'h401E);
      @(posedge core_clk);
      fault <= 4'(cm[k] >> 1);
      wait_drop(1'b1, 100, n);
      chk("drop_latency", 16'(n <= 54), 16'h0001);
      @(posedge core_clk);
      fault <= 4'h0;
      // let the window that still saw the fault close before reading
      tick(60);
      wait_drop(1'b0, 400, n);
      rchk("cause_flags", 8'h2D, 16'h401E | (cm[k] << 8));
      rchk("cause_cleared", 8'h2D, 16'h401E);
    end
    // silence on the wire, with and without the wait interval
    for (int w = 0; w < 2; w++) begin
      wr(8'h2D, w == 0 ? 16'hC000 : 16'h8000);
      @(posedge core_clk);
      present <= 1'b0;
      wait_drop(1'b1, 3000, n);
      chk("silence_drop", 16'(w == 0 ? n <= 4 : n > 2490 && n < 2510), 16'h0001);
      @(posedge core_clk);
      present <= 1'b1;
      wait_drop(1'b0, 400, n);
      chk("drop_released", 16'(link_drop), 16'h0000);
    end
    wrap_up();
  end
endmodule : test_link_drop_crossover_config
`default_nettype wire
